//--- inc/uisc_params.svh
/*
  Register offsets, field positions and reset values of the serial-port
  event status, enable and clear logic. Assumes inclusion by bare name.
*/
`ifndef UISC_PARAMS_SVH
`define UISC_PARAMS_SVH

`define UISC_ADDR_W        8
`define UISC_DATA_W        32
`define UISC_NUM_EVT       11
`define UISC_OFS_ENABLE    8'h38
`define UISC_OFS_RAW       8'h3c
`define UISC_OFS_MASKED    8'h40
`define UISC_OFS_CLEAR     8'h44
`define UISC_EVT_RESET     11'h000
`define UISC_RDATA_RESET   32'h0000_0000
`define UISC_RSVD_W        21

`define UISC_BIT_OVERRUN   10
`define UISC_BIT_BREAK     9
`define UISC_BIT_PARITY    8
`define UISC_BIT_FRAMING   7
`define UISC_BIT_RX_TMO    6
`define UISC_BIT_TX_EVT    5
`define UISC_BIT_RX_EVT    4
`define UISC_BIT_DSR       3
`define UISC_BIT_DCD       2
`define UISC_BIT_CTS       1
`define UISC_BIT_TXCMP     0

`endif

//--- inc/uisc_pkg.sv
/*
  Types shared by the serial-port event status logic.
  Assumes uisc_params.svh is on the include path.
*/
`include "uisc_params.svh"

package uisc_pkg;
  typedef logic [`UISC_NUM_EVT-1:0] uisc_evt_t;
  typedef logic [`UISC_ADDR_W-1:0]  uisc_addr_t;
  typedef logic [`UISC_DATA_W-1:0]  uisc_data_t;
endpackage : uisc_pkg

//--- hw/uisc_event_ctrl.sv
/*
  Event status, enable and clear registers of one serial-port instance,
  with one level interrupt output.
  Each event input sets a sticky raw bit; software clears it by writing
  a one to the matching clear bit, and an event wins over a clear that
  lands in the same cycle. The enable register gates the masked status,
  and the interrupt is high while any masked bit is set.
  Reserved bits read as zero and ignore writes; unmapped offsets read zero.
  Assumes a single synchronous clock, event inputs as one-cycle or level
  pulses from the serial datapath, and a plain strobe register port with
  read data in the cycle after the read strobe only.
  An event input held high keeps setting its bit, so a clear only sticks
  once the source has dropped it.
  A second instance is made by instantiating this module again; the
  window base decode sits outside this block.
*/
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "uisc_params.svh"

// Contract
// - Raw status read-only, reset zero; overrun bit10, break 9, parity 8, framing 7.
// - Raw status has receive timeout bit6, transmit bit5, receive bit4.
// - Raw status has DSR change bit3, DCD bit2, CTS bit1, transmit-complete bit0.
// - Masked status read-only, reset zero, equals raw status AND enable per bit.
// - Clear register write-only; writing a bit clears the matching pending status.
// - Bits 31 to 11 of these registers read zero; writes there ignored.
// - Two independent identical instances at same offsets in separate windows.
// - Enable register at 0x38, read-write, reset zero, same bit layout.
module uisc_event_ctrl
  import uisc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       overrun_evt,
  input  wire logic       break_error_evt,
  input  wire logic       parity_error_evt,
  input  wire logic       framing_error_evt,
  input  wire logic       rx_timeout_evt,
  input  wire logic       transmit_evt,
  input  wire logic       receive_evt,
  input  wire logic       modem_dataset_ready_evt,
  input  wire logic       modem_carrier_evt,
  input  wire logic       modem_clear_to_send_evt,
  input  wire logic       transmit_complete_evt,
  input  wire uisc_addr_t addr,
  input  wire uisc_data_t wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output uisc_data_t      rdata,
  output logic            irq
);

  // Register state and next values
  uisc_evt_t  raw_event_status;
  uisc_evt_t  event_enable;
  uisc_evt_t  masked_event_status;
  uisc_evt_t  evt_in;
  uisc_evt_t  clr_mask;
  uisc_evt_t  next_raw;
  uisc_evt_t  next_enable;
  uisc_data_t next_rdata;

  // Decoded selects and strobes
  logic       sel_enable;
  logic       sel_raw;
  logic       sel_masked;
  logic       sel_clear;
  logic       enable_wr;
  logic       clear_wr;
  logic       rd_enable;
  logic       rd_raw;
  logic       rd_masked;
  logic       rd_clear;

  // Per-source raw status
  logic       overrun_raw;
  logic       break_error_raw;
  logic       parity_error_raw;
  logic       framing_error_raw;
  logic       rx_timeout_raw;
  logic       transmit_event_raw;
  logic       receive_event_raw;
  logic       modem_dataset_ready_raw;
  logic       modem_carrier_raw;
  logic       modem_clear_to_send_raw;
  logic       transmit_complete_raw;

  // Per-source enables
  logic       overrun_enable;
  logic       break_error_enable;
  logic       parity_error_enable;
  logic       framing_error_enable;
  logic       rx_timeout_enable;
  logic       transmit_event_enable;
  logic       receive_event_enable;
  logic       modem_dataset_ready_enable;
  logic       modem_carrier_enable;
  logic       modem_clear_to_send_enable;
  logic       transmit_complete_enable;

  // Per-source masked status
  logic       overrun_masked;
  logic       break_error_masked;
  logic       parity_error_masked;
  logic       framing_error_masked;
  logic       rx_timeout_masked;
  logic       transmit_event_masked;
  logic       receive_event_masked;
  logic       modem_dataset_ready_masked;
  logic       modem_carrier_masked;
  logic       modem_clear_to_send_masked;
  logic       transmit_complete_masked;

  // Per-source clear strobes
  logic       overrun_clear;
  logic       break_error_clear;
  logic       parity_error_clear;
  logic       framing_error_clear;
  logic       rx_timeout_clear;
  logic       transmit_event_clear;
  logic       receive_event_clear;
  logic       modem_dataset_ready_clear;
  logic       modem_carrier_clear;
  logic       modem_clear_to_send_clear;
  logic       transmit_complete_clear;

  // Only the offset is decoded, so every instance answers at the same offsets
  function automatic logic hit(input uisc_addr_t a, input uisc_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  // Reserved upper bits of every status word read as zero
  function automatic uisc_data_t to_word(input uisc_evt_t v);
    to_word = {{`UISC_RSVD_W{1'b0}}, v};
  endfunction : to_word

  // Event inputs placed at their status bit positions
  always_comb begin
    evt_in                      = `UISC_EVT_RESET;
    evt_in[`UISC_BIT_OVERRUN]   = overrun_evt;
    evt_in[`UISC_BIT_BREAK]     = break_error_evt;
    evt_in[`UISC_BIT_PARITY]    = parity_error_evt;
    evt_in[`UISC_BIT_FRAMING]   = framing_error_evt;
    evt_in[`UISC_BIT_RX_TMO]    = rx_timeout_evt;
    evt_in[`UISC_BIT_TX_EVT]    = transmit_evt;
    evt_in[`UISC_BIT_RX_EVT]    = receive_evt;
    evt_in[`UISC_BIT_DSR]       = modem_dataset_ready_evt;
    evt_in[`UISC_BIT_DCD]       = modem_carrier_evt;
    evt_in[`UISC_BIT_CTS]       = modem_clear_to_send_evt;
    evt_in[`UISC_BIT_TXCMP]     = transmit_complete_evt;
  end

  // Bus selects, one per mapped offset
  assign sel_enable = hit(addr, `UISC_OFS_ENABLE);
  assign sel_raw    = hit(addr, `UISC_OFS_RAW);
  assign sel_masked = hit(addr, `UISC_OFS_MASKED);
  assign sel_clear  = hit(addr, `UISC_OFS_CLEAR);

  // Raw and masked status have no write path, so writes there are ignored
  assign enable_wr  = wr_en && sel_enable;
  assign clear_wr   = wr_en && sel_clear;

  assign rd_enable  = rd_en && sel_enable;
  assign rd_raw     = rd_en && sel_raw;
  assign rd_masked  = rd_en && sel_masked;
  assign rd_clear   = rd_en && sel_clear;

  // Only the low bits of a clear write matter; upper bits are dropped
  assign overrun_clear             = clear_wr && wdata[`UISC_BIT_OVERRUN];
  assign break_error_clear         = clear_wr && wdata[`UISC_BIT_BREAK];
  assign parity_error_clear        = clear_wr && wdata[`UISC_BIT_PARITY];
  assign framing_error_clear       = clear_wr && wdata[`UISC_BIT_FRAMING];
  assign rx_timeout_clear          = clear_wr && wdata[`UISC_BIT_RX_TMO];
  assign transmit_event_clear      = clear_wr && wdata[`UISC_BIT_TX_EVT];
  assign receive_event_clear       = clear_wr && wdata[`UISC_BIT_RX_EVT];
  assign modem_dataset_ready_clear = clear_wr && wdata[`UISC_BIT_DSR];
  assign modem_carrier_clear       = clear_wr && wdata[`UISC_BIT_DCD];
  assign modem_clear_to_send_clear = clear_wr && wdata[`UISC_BIT_CTS];
  assign transmit_complete_clear   = clear_wr && wdata[`UISC_BIT_TXCMP];

  always_comb begin
    clr_mask                    = `UISC_EVT_RESET;
    clr_mask[`UISC_BIT_OVERRUN] = overrun_clear;
    clr_mask[`UISC_BIT_BREAK]   = break_error_clear;
    clr_mask[`UISC_BIT_PARITY]  = parity_error_clear;
    clr_mask[`UISC_BIT_FRAMING] = framing_error_clear;
    clr_mask[`UISC_BIT_RX_TMO]  = rx_timeout_clear;
    clr_mask[`UISC_BIT_TX_EVT]  = transmit_event_clear;
    clr_mask[`UISC_BIT_RX_EVT]  = receive_event_clear;
    clr_mask[`UISC_BIT_DSR]     = modem_dataset_ready_clear;
    clr_mask[`UISC_BIT_DCD]     = modem_carrier_clear;
    clr_mask[`UISC_BIT_CTS]     = modem_clear_to_send_clear;
    clr_mask[`UISC_BIT_TXCMP]   = transmit_complete_clear;
  end

  // Set beats clear so an event landing on a clear write is not lost
  for (genvar i = 0; i < `UISC_NUM_EVT; i++) begin : g_next_raw
    assign next_raw[i] = (raw_event_status[i] & ~clr_mask[i]) | evt_in[i];
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      raw_event_status <= `UISC_EVT_RESET;
    end else begin
      raw_event_status <= next_raw;
    end
  end

  // Named views of the raw status
  assign overrun_raw             = raw_event_status[`UISC_BIT_OVERRUN];
  assign break_error_raw         = raw_event_status[`UISC_BIT_BREAK];
  assign parity_error_raw        = raw_event_status[`UISC_BIT_PARITY];
  assign framing_error_raw       = raw_event_status[`UISC_BIT_FRAMING];
  assign rx_timeout_raw          = raw_event_status[`UISC_BIT_RX_TMO];
  assign transmit_event_raw      = raw_event_status[`UISC_BIT_TX_EVT];
  assign receive_event_raw       = raw_event_status[`UISC_BIT_RX_EVT];
  assign modem_dataset_ready_raw = raw_event_status[`UISC_BIT_DSR];
  assign modem_carrier_raw       = raw_event_status[`UISC_BIT_DCD];
  assign modem_clear_to_send_raw = raw_event_status[`UISC_BIT_CTS];
  assign transmit_complete_raw   = raw_event_status[`UISC_BIT_TXCMP];

  // Named views of the enables
  assign overrun_enable             = event_enable[`UISC_BIT_OVERRUN];
  assign break_error_enable         = event_enable[`UISC_BIT_BREAK];
  assign parity_error_enable        = event_enable[`UISC_BIT_PARITY];
  assign framing_error_enable       = event_enable[`UISC_BIT_FRAMING];
  assign rx_timeout_enable          = event_enable[`UISC_BIT_RX_TMO];
  assign transmit_event_enable      = event_enable[`UISC_BIT_TX_EVT];
  assign receive_event_enable       = event_enable[`UISC_BIT_RX_EVT];
  assign modem_dataset_ready_enable = event_enable[`UISC_BIT_DSR];
  assign modem_carrier_enable       = event_enable[`UISC_BIT_DCD];
  assign modem_clear_to_send_enable = event_enable[`UISC_BIT_CTS];
  assign transmit_complete_enable   = event_enable[`UISC_BIT_TXCMP];

  // Each masked bit is its raw bit gated by its own enable
  assign overrun_masked             = overrun_raw & overrun_enable;
  assign break_error_masked         = break_error_raw & break_error_enable;
  assign parity_error_masked        = parity_error_raw & parity_error_enable;
  assign framing_error_masked       = framing_error_raw & framing_error_enable;
  assign rx_timeout_masked          = rx_timeout_raw & rx_timeout_enable;
  assign transmit_event_masked      = transmit_event_raw & transmit_event_enable;
  assign receive_event_masked       = receive_event_raw & receive_event_enable;
  assign modem_dataset_ready_masked = modem_dataset_ready_raw & modem_dataset_ready_enable;
  assign modem_carrier_masked       = modem_carrier_raw & modem_carrier_enable;
  assign modem_clear_to_send_masked = modem_clear_to_send_raw & modem_clear_to_send_enable;
  assign transmit_complete_masked   = transmit_complete_raw & transmit_complete_enable;

  always_comb begin
    masked_event_status                    = `UISC_EVT_RESET;
    masked_event_status[`UISC_BIT_OVERRUN] = overrun_masked;
    masked_event_status[`UISC_BIT_BREAK]   = break_error_masked;
    masked_event_status[`UISC_BIT_PARITY]  = parity_error_masked;
    masked_event_status[`UISC_BIT_FRAMING] = framing_error_masked;
    masked_event_status[`UISC_BIT_RX_TMO]  = rx_timeout_masked;
    masked_event_status[`UISC_BIT_TX_EVT]  = transmit_event_masked;
    masked_event_status[`UISC_BIT_RX_EVT]  = receive_event_masked;
    masked_event_status[`UISC_BIT_DSR]     = modem_dataset_ready_masked;
    masked_event_status[`UISC_BIT_DCD]     = modem_carrier_masked;
    masked_event_status[`UISC_BIT_CTS]     = modem_clear_to_send_masked;
    masked_event_status[`UISC_BIT_TXCMP]   = transmit_complete_masked;
  end

  // Level output; stays high until every set bit is cleared or masked
  assign irq = |masked_event_status;

  always_comb begin
    next_enable = event_enable;
    if (enable_wr) begin
      next_enable = wdata[`UISC_NUM_EVT-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      event_enable <= `UISC_EVT_RESET;
    end else begin
      event_enable <= next_enable;
    end
  end

  // Read data valid in the cycle after the strobe only; zero otherwise
  always_comb begin
    next_rdata = `UISC_RDATA_RESET;
    if (rd_raw) begin
      next_rdata = to_word(raw_event_status);
    end else if (rd_masked) begin
      next_rdata = to_word(masked_event_status);
    end else if (rd_enable) begin
      next_rdata = to_word(event_enable);
    end else if (rd_clear) begin
      next_rdata = `UISC_RDATA_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata <= `UISC_RDATA_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : uisc_event_ctrl

//--- dv/uisc_event_ctrl_checker.sv
/* Port assertions for uisc_event_ctrl.
   Assumes one clock and the bind at the foot. */
`timescale 1ns/1ps
module uisc_event_ctrl_checker
  import uisc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       overrun_evt,
  input wire logic       transmit_complete_evt,
  input wire uisc_addr_t addr,
  input wire uisc_data_t wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire uisc_data_t rdata,
  input wire logic       irq
);
  wire rd3c = rd_en && addr == 8'h3c;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!rd_en |=> rdata == 32'h0) else $error("rdata not idle");
  a_rsvd_zero: assert property (rd_en |=> rdata[31:11] == 21'h0) else $error("upper bits set");
  a_clr_reads_zero: assert property (rd_en && addr == 8'h44 |=> rdata == 32'h0) else $error("clear read");
  a_ovr_sets: assert property (overrun_evt ##1 rd3c |=> rdata[10]) else $error("overrun lost");
  a_txc_sets: assert property (transmit_complete_evt ##1 rd3c |=> rdata[0]) else $error("txcmp lost");
  a_irq_reset: assert property ($rose(rstn) |-> !irq) else $error("irq after reset");
  a_clr_works: assert property (wr_en && addr == 8'h44 && wdata[10] && !overrun_evt ##1 rd3c |=> !rdata[10])
    else $error("clear failed");
  a_irq_masked: assert property (rd_en && addr == 8'h40 |=> (rdata != 32'h0) == $past(irq)) else $error("irq");
  c_irq: cover property (irq);
  c_clear: cover property (wr_en && addr == 8'h44);
  c_ovr: cover property (overrun_evt ##1 rd3c);
endmodule : uisc_event_ctrl_checker
bind uisc_event_ctrl uisc_event_ctrl_checker i_chk (.ref_clk, .rstn, .overrun_evt, .transmit_complete_evt,
  .addr, .wdata, .wr_en, .rd_en, .rdata, .irq);

//--- dv/test_uisc_event_ctrl.sv
/* Self-checking bench for uisc_event_ctrl.
   Assumes the checker is bound in. */
`timescale 1ns/1ps
module test_uisc_event_ctrl import uisc_pkg::*;;
  logic       ref_clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, irq;
  uisc_evt_t  ev = 11'h0;
  uisc_addr_t addr = 8'h0;
  uisc_data_t wdata = 32'h0, rdata;
  int         mismatches = 0, check_count = 0;
  uisc_event_ctrl i_dut (.ref_clk, .rstn, .overrun_evt(ev[10]), .break_error_evt(ev[9]), .parity_error_evt(ev[8]),
    .framing_error_evt(ev[7]), .rx_timeout_evt(ev[6]), .transmit_evt(ev[5]), .receive_evt(ev[4]),
    .modem_dataset_ready_evt(ev[3]), .modem_carrier_evt(ev[2]), .modem_clear_to_send_evt(ev[1]),
    .transmit_complete_evt(ev[0]), .addr, .wdata, .wr_en, .rd_en, .rdata, .irq);
  initial forever #10 ref_clk = ~ref_clk;
  task chk(uisc_data_t g, uisc_data_t e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task chk_irq(logic e);
    check_count++;
    if (irq !== e) begin
      mismatches++;
      $display("mismatch %0t irq %b exp %b", $time, irq, e);
    end
  endtask : chk_irq
  // Every access drives all inputs, so strobes and events never linger
  task acc(logic w, logic r, uisc_addr_t a, uisc_data_t d, uisc_evt_t m);
    @(posedge ref_clk) {wr_en, rd_en, addr, wdata, ev} <= {w, r, a, d, m};
  endtask : acc
  task rd(uisc_addr_t a, uisc_data_t e);
    acc(1'b0, 1'b1, a, 32'h0, 11'h0);
    acc(1'b0, 1'b0, a, 32'h0, 11'h0);
    #1 chk(rdata, e);
  endtask : rd
  task t_reset;
    for (int a = 8'h38; a <= 8'h48; a += 8'h4) rd(a[7:0], 32'h0);
  endtask : t_reset
  task t_bits;
    for (int k = 0; k < 11; k++) begin
      acc(1'b0, 1'b0, 8'h0, 32'h0, 11'h1 << k);
      rd(8'h3c, 32'h1 << k);
      rd(8'h40, 32'h0);
      acc(1'b1, 1'b0, 8'h44, 32'h1 << k, 11'h0);
      rd(8'h3c, 32'h0);
    end
  endtask : t_bits
  task t_mask;
    acc(1'b1, 1'b0, 8'h38, 32'hffff_ffff, 11'h0);
    rd(8'h38, 32'h7ff);
    acc(1'b0, 1'b0, 8'h0, 32'h0, 11'h7ff);
    acc(1'b1, 1'b0, 8'h3c, 32'h0, 11'h0);
    acc(1'b1, 1'b0, 8'h44, 32'hffff_f800, 11'h0);
    rd(8'h40, 32'h7ff);
    chk_irq(1'b1);
    acc(1'b1, 1'b0, 8'h44, 32'h400, 11'h0);
    acc(1'b1, 1'b0, 8'h38, 32'h400, 11'h0);
    rd(8'h3c, 32'h3ff);
    chk_irq(1'b0);
    rd(8'h44, 32'h0);
  endtask : t_mask
  // Event and clear in one cycle, then a reset in mid-run
  task t_rst;
    acc(1'b1, 1'b0, 8'h38, 32'h7ff, 11'h0);
    acc(1'b1, 1'b0, 8'h44, 32'h7ff, 11'h1);
    rd(8'h3c, 32'h1);
    chk_irq(1'b1);
    @(posedge ref_clk) rstn <= 1'b0;
    @(posedge ref_clk) rstn <= 1'b1;
    #1 chk_irq(1'b0);
    rd(8'h3c, 32'h0);
    rd(8'h38, 32'h0);
  endtask : t_rst
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_bits;
    t_mask;
    t_rst;
    end_of_test;
  end
  // The tests need some 126 cycles; this is nearly sixteen times that
  initial begin
    #40000;
    mismatches++;
    end_of_test;
  end
endmodule : test_uisc_event_ctrl
